/* File: rtl/battery_switch_alert_config.sv */
// two configuration registers of the charger: buck rate, timer doubling,
// battery switch control with ship/restart pin timing, alert masks and
// port probing; the serial front end delivers decoded byte accesses
`timescale 1ns/1ps
`default_nettype none

module battery_switch_alert_config #(
  parameter int unsigned MS_CYCLES = switch_alert_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // register access from the serial front end
  input wire switch_alert_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // restore events
  input wire logic reg_reset,
  input wire logic host_watchdog_expiry,
  // pins and analog events, asynchronous
  input wire logic ship_reset_pin_n,
  input wire switch_alert_pkg::fault_in_t faults,
  // controls
  output logic buck_switching_rate,
  output logic timer_doubling_enable,
  output logic battery_switch_on,
  output logic port_probe_enable,
  output logic host_alert
);

  switch_alert_pkg::state_t s_reg;
  switch_alert_pkg::state_t s_next;

  function automatic logic [13:0] off_ms(input logic [1:0] sel);
    case (sel)
      2'h0: off_ms = switch_alert_pkg::RESTART_OFF_0_5S_MS;
      2'h1: off_ms = switch_alert_pkg::RESTART_OFF_2S_MS;
      2'h2: off_ms = switch_alert_pkg::RESTART_OFF_4S_MS;
      default: off_ms = switch_alert_pkg::RESTART_OFF_8S_MS;
    endcase
  endfunction

  function automatic logic [13:0] hold_ms(input logic [1:0] sel);
    case (sel)
      2'h0: hold_ms = switch_alert_pkg::SHIP_HOLD_8S_MS;
      2'h1: hold_ms = switch_alert_pkg::SHIP_HOLD_10S_MS;
      2'h2: hold_ms = switch_alert_pkg::SHIP_HOLD_12S_MS;
      default: hold_ms = switch_alert_pkg::SHIP_HOLD_16S_MS;
    endcase
  endfunction

  logic pin_low;
  logic ms_tick;
  logic sw_mode;
  logic [13:0] hold_target;
  logic [13:0] off_target;
  logic wr_power;
  logic wr_alert;

  assign pin_low = ~s_reg.pin_sync[1];
  assign ms_tick = s_reg.prescale == 16'(MS_CYCLES - 1);
  assign sw_mode = s_reg.power_cfg[switch_alert_pkg::BIT_RESTART_MODE_SELECT];
  assign hold_target = hold_ms(s_reg.power_cfg[
    switch_alert_pkg::LSB_SHIP_ENTRY_HOLD_TIME +: 2]);
  assign off_target = off_ms(s_reg.power_cfg[
    switch_alert_pkg::LSB_RESTART_OFF_TIME +: 2]);
  assign wr_power = reg_req.wr &&
    reg_req.addr == switch_alert_pkg::OFS_POWER_SWITCH_CONFIG;
  assign wr_alert = reg_req.wr &&
    reg_req.addr == switch_alert_pkg::OFS_ALERT_MASK_AND_PORT_PROBE;

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    logic counting;
    logic restart;
    counting = 1'b0;
    restart = 1'b0;
    s_next = s_reg;

    // synchronisers: the first stage feeds only the second
    s_next.pin_sync = {s_reg.pin_sync[0], ship_reset_pin_n};
    s_next.flt_meta = faults;
    s_next.flt_sync = s_reg.flt_meta;

    // restores win over a same-cycle write
    if (reg_reset) begin
      s_next.power_cfg = (s_reg.power_cfg &
        switch_alert_pkg::KEEP_ON_REG_RESET) |
        (switch_alert_pkg::POWER_SWITCH_CONFIG_RESET &
        ~switch_alert_pkg::KEEP_ON_REG_RESET);
      s_next.alert_cfg = switch_alert_pkg::ALERT_MASK_RESET;
    end else if (host_watchdog_expiry) begin
      s_next.power_cfg = (s_reg.power_cfg &
        switch_alert_pkg::KEEP_ON_WATCHDOG) |
        (switch_alert_pkg::POWER_SWITCH_CONFIG_RESET &
        ~switch_alert_pkg::KEEP_ON_WATCHDOG);
      s_next.alert_cfg = switch_alert_pkg::ALERT_MASK_RESET;
    end else begin
      if (wr_power) begin
        s_next.power_cfg = reg_req.wdata;
      end
      if (wr_alert) begin
        s_next.alert_cfg = reg_req.wdata &
          switch_alert_pkg::ALERT_MASK_WRITABLE;
      end
    end

    if (reg_req.rd) begin
      case (reg_req.addr)
        switch_alert_pkg::OFS_POWER_SWITCH_CONFIG:
          s_next.rdata = s_reg.power_cfg;
        switch_alert_pkg::OFS_ALERT_MASK_AND_PORT_PROBE:
          s_next.rdata = s_reg.alert_cfg;
        default:
          s_next.rdata = switch_alert_pkg::UNMAPPED_READ;
      endcase
    end

    // ship / restart sequencing on the synchronised pin
    case (s_reg.fsm)
      switch_alert_pkg::ST_ON: begin
        if (pin_low) begin
          s_next.fsm = switch_alert_pkg::ST_HOLD;
          restart = 1'b1;
        end
      end
      switch_alert_pkg::ST_HOLD: begin
        counting = 1'b1;
        if (!pin_low) begin
          s_next.fsm = switch_alert_pkg::ST_ON;
        end else if (s_reg.ms_cnt >= hold_target) begin
          restart = 1'b1;
          s_next.fsm = sw_mode ? switch_alert_pkg::ST_RESTART_OFF
                               : switch_alert_pkg::ST_SHIP_OFF;
        end
      end
      switch_alert_pkg::ST_RESTART_OFF: begin
        counting = 1'b1;
        if (s_reg.ms_cnt >= off_target) begin
          s_next.fsm = switch_alert_pkg::ST_WAIT_HIGH;
        end
      end
      switch_alert_pkg::ST_WAIT_HIGH: begin
        // re-arm only after release, so one long press acts once
        if (!pin_low) begin
          s_next.fsm = switch_alert_pkg::ST_ON;
        end
      end
      switch_alert_pkg::ST_SHIP_OFF: begin
        if (!pin_low) begin
          s_next.fsm = switch_alert_pkg::ST_SHIP_IDLE;
        end
      end
      switch_alert_pkg::ST_SHIP_IDLE: begin
        if (pin_low) begin
          s_next.fsm = switch_alert_pkg::ST_WAKE;
          restart = 1'b1;
        end
      end
      switch_alert_pkg::ST_WAKE: begin
        counting = 1'b1;
        if (!pin_low) begin
          s_next.fsm = switch_alert_pkg::ST_SHIP_IDLE;
        end else if (s_reg.ms_cnt >= off_target) begin
          s_next.fsm = switch_alert_pkg::ST_WAIT_HIGH;
        end
      end
      default: begin
        s_next.fsm = switch_alert_pkg::ST_ON;
      end
    endcase

    if (restart || !counting) begin
      s_next.prescale = 16'h0000;
      s_next.ms_cnt = 14'h0000;
    end else if (ms_tick) begin
      s_next.prescale = 16'h0000;
      s_next.ms_cnt = s_reg.ms_cnt + 14'h0001;
    end else begin
      s_next.prescale = s_reg.prescale + 16'h0001;
    end

    s_next.switch_on = !s_next.power_cfg[
      switch_alert_pkg::BIT_BATTERY_SWITCH_FORCE_OFF] &&
      (s_next.fsm == switch_alert_pkg::ST_ON ||
       s_next.fsm == switch_alert_pkg::ST_HOLD ||
       s_next.fsm == switch_alert_pkg::ST_WAIT_HIGH);

    s_next.alert =
      (s_reg.alert_cfg[switch_alert_pkg::BIT_ALERT_MASK_HI] &&
       (s_reg.flt_sync[2] || s_reg.flt_sync[1])) ||
      (s_reg.alert_cfg[switch_alert_pkg::BIT_ALERT_MASK_LO] &&
       s_reg.flt_sync[0]);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= switch_alert_pkg::STATE_RESET;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign reg_rdata = s_reg.rdata;
  assign buck_switching_rate =
    s_reg.power_cfg[switch_alert_pkg::BIT_BUCK_SWITCHING_RATE];
  assign timer_doubling_enable =
    s_reg.power_cfg[switch_alert_pkg::BIT_TIMER_DOUBLING_ENABLE];
  assign battery_switch_on = s_reg.switch_on;
  assign port_probe_enable =
    s_reg.alert_cfg[switch_alert_pkg::BIT_PORT_PROBE_ENABLE];
  assign host_alert = s_reg.alert;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_rate_write: assert property (
    clk_en && wr_power && !reg_reset && !host_watchdog_expiry |=>
    buck_switching_rate == $past(reg_req.wdata[7]))
    else $error("buck rate did not follow write");
  chk_timer_restore: assert property (
    clk_en && host_watchdog_expiry |=> timer_doubling_enable)
    else $error("timer doubling not restored");
  chk_force_kept: assert property (
    clk_en && (reg_reset || host_watchdog_expiry) |=>
    s_reg.power_cfg[5] == $past(s_reg.power_cfg[5]))
    else $error("force-off bit lost on restore");
  chk_force_holds_off: assert property (
    s_reg.power_cfg[5] |-> !battery_switch_on)
    else $error("switch on while forced off");
  chk_mode_restore: assert property (
    clk_en && reg_reset |=> s_reg.power_cfg[4])
    else $error("restart mode not restored");
  chk_mode_wdt_kept: assert property (
    clk_en && host_watchdog_expiry && !reg_reset |=>
    s_reg.power_cfg[4] == $past(s_reg.power_cfg[4]))
    else $error("restart mode changed by watchdog");
  chk_restart_off: assert property (
    s_reg.fsm == switch_alert_pkg::ST_RESTART_OFF |-> !battery_switch_on)
    else $error("switch on during restart-off");
  chk_ship_off: assert property (
    s_reg.fsm == switch_alert_pkg::ST_SHIP_IDLE |-> !battery_switch_on)
    else $error("switch on in ship mode");
  chk_hold_exit: assert property (
    clk_en && s_reg.fsm == switch_alert_pkg::ST_HOLD && pin_low &&
    s_reg.ms_cnt >= hold_target |=> s_reg.fsm != switch_alert_pkg::ST_HOLD)
    else $error("hold time expiry missed");
  chk_alert_masked: assert property (
    clk_en && !s_reg.alert_cfg[7] && !s_reg.alert_cfg[6] |=> !host_alert)
    else $error("alert raised while masked");
  chk_alert_ovp: assert property (
    clk_en && s_reg.alert_cfg[6] && s_reg.flt_sync[0] |=> host_alert)
    else $error("overvoltage alert missing");
  chk_probe_write: assert property (
    clk_en && wr_alert && !reg_reset && !host_watchdog_expiry |=>
    port_probe_enable == $past(reg_req.wdata[5]))
    else $error("port probe did not follow write");
  chk_reserved_zero: assert property (
    clk_en && reg_req.rd &&
    reg_req.addr == switch_alert_pkg::OFS_ALERT_MASK_AND_PORT_PROBE |=>
    reg_rdata[4:0] == 5'h00)
    else $error("reserved bits read nonzero");

endmodule

`default_nettype wire

/* File: rtl/switch_alert_pkg.sv */
// constants, field layouts and carrier types for the battery switch and
// alert configuration block; assumes a 40 MHz clock and a byte-wide
// register port fed by the device's serial host interface
package switch_alert_pkg;

  // -------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------
  localparam logic [7:0] OFS_POWER_SWITCH_CONFIG = 8'h0A;
  localparam logic [7:0] OFS_ALERT_MASK_AND_PORT_PROBE = 8'h0B;

  // power_switch_config fields
  localparam int BIT_BUCK_SWITCHING_RATE = 7;
  localparam int BIT_TIMER_DOUBLING_ENABLE = 6;
  localparam int BIT_BATTERY_SWITCH_FORCE_OFF = 5;
  localparam int BIT_RESTART_MODE_SELECT = 4;
  localparam int LSB_RESTART_OFF_TIME = 2;
  localparam int LSB_SHIP_ENTRY_HOLD_TIME = 0;
  localparam logic [7:0] POWER_SWITCH_CONFIG_RESET = 8'h58;
  // bits that survive a register reset and a watchdog expiry
  localparam logic [7:0] KEEP_ON_REG_RESET = 8'h20;
  localparam logic [7:0] KEEP_ON_WATCHDOG = 8'h30;

  // alert_mask_and_port_probe fields
  localparam int BIT_ALERT_MASK_HI = 7;
  localparam int BIT_ALERT_MASK_LO = 6;
  localparam int BIT_PORT_PROBE_ENABLE = 5;
  localparam logic [7:0] ALERT_MASK_RESET = 8'hC0;
  localparam logic [7:0] ALERT_MASK_WRITABLE = 8'hE0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // -------------------------------------------------------------------
  // timing: clock in Hz, ms tick in cycles, times in milliseconds
  // -------------------------------------------------------------------
  localparam int unsigned CLOCK_HZ = 40000000;
  localparam int unsigned MS_CYCLES = CLOCK_HZ / 1000;
  localparam logic [13:0] RESTART_OFF_0_5S_MS = 14'h01F4;
  localparam logic [13:0] RESTART_OFF_2S_MS = 14'h07D0;
  localparam logic [13:0] RESTART_OFF_4S_MS = 14'h0FA0;
  localparam logic [13:0] RESTART_OFF_8S_MS = 14'h1F40;
  localparam logic [13:0] SHIP_HOLD_8S_MS = 14'h1F40;
  localparam logic [13:0] SHIP_HOLD_10S_MS = 14'h2710;
  localparam logic [13:0] SHIP_HOLD_12S_MS = 14'h2EE0;
  localparam logic [13:0] SHIP_HOLD_16S_MS = 14'h3E80;

  // -------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_ON, ST_HOLD, ST_RESTART_OFF, ST_WAIT_HIGH,
    ST_SHIP_OFF, ST_SHIP_IDLE, ST_WAKE
  } ship_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // bit 2 thermal shutdown, bit 1 safety timer, bit 0 battery overvoltage
  typedef struct packed {
    logic thermal_shutdown;
    logic safety_timer_fault;
    logic battery_overvoltage_fault;
  } fault_in_t;

  typedef struct packed {
    logic [7:0] power_cfg;
    logic [7:0] alert_cfg;
    logic [1:0] pin_sync;
    logic [2:0] flt_meta;
    logic [2:0] flt_sync;
    ship_state_t fsm;
    logic [15:0] prescale;
    logic [13:0] ms_cnt;
    logic [7:0] rdata;
    logic alert;
    logic switch_on;
  } state_t;

  localparam state_t STATE_RESET = '{
    power_cfg: POWER_SWITCH_CONFIG_RESET,
    alert_cfg: ALERT_MASK_RESET,
    pin_sync: 2'h3,
    flt_meta: 3'h0,
    flt_sync: 3'h0,
    fsm: ST_ON,
    prescale: 16'h0000,
    ms_cnt: 14'h0000,
    rdata: 8'h00,
    alert: 1'b0,
    switch_on: 1'b1
  };

endpackage

/* File: verif/host_model.sv */
// host side model: byte register accesses and the ship/reset pin driver
// assumes the block samples requests on the rising edge of clock
`timescale 1ns/1ps
`default_nettype none

module host_model (
  // clock
  input wire logic clock,
  // register port
  output var switch_alert_pkg::reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  // ship/reset pin
  output var logic ship_reset_pin_n
);
  initial begin
    reg_req = '{addr: 8'hFF, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
    ship_reset_pin_n = 1'b1;
  end

  // released address and data show the inverse, never a stale match
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge clock);
    reg_req = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge clock);
    reg_req = '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
    @(negedge clock);
    d = reg_rdata;
  endtask

  // the caller holds the level for the whole hold or pulse time
  task automatic set_pin(input logic v);
    @(negedge clock);
    ship_reset_pin_n = v;
  endtask
endmodule

`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the battery switch and alert configuration
// assumes host_model drives the register port and ship/reset pin
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ms tick shortened so second-long holds stay short
  localparam int unsigned MSC = 2;
  logic clock, rst_n, reg_reset, wdog, clk_en;
  switch_alert_pkg::fault_in_t faults;
  switch_alert_pkg::reg_req_t reg_req;
  logic [7:0] reg_rdata, d;
  logic pin_n, rate, timer, sw_on, probe, alert;
  int error_cnt, compares, n;

  host_model host_model_i (.clock(clock), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .ship_reset_pin_n(pin_n));

  battery_switch_alert_config #(.MS_CYCLES(MSC))
    battery_switch_alert_config_i (.clock(clock), .rst_n(rst_n),
    .clk_en(clk_en), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_reset(reg_reset), .host_watchdog_expiry(wdog),
    .ship_reset_pin_n(pin_n), .faults(faults),
    .buck_switching_rate(rate), .timer_doubling_enable(timer),
    .battery_switch_on(sw_on), .port_probe_enable(probe),
    .host_alert(alert));

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host_model_i.write_reg(a, v);
    @(negedge clock);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host_model_i.read_reg(a, d);
    check(d, exp);
  endtask

  task automatic wait_switch(input logic v, input int max);
    n = 0;
    while (sw_on !== v) begin
      @(negedge clock);
      n++;
      if (n > max) begin
        check(sw_on, v);
        print_verdict();
      end
    end
  endtask

  task automatic band(input int lo, input int hi);
    check(n >= lo && n <= hi, 1'b1);
  endtask

  // -------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------
  task automatic test_reset();
    rd_chk(8'h0A, 8'h58);
    rd_chk(8'h0B, 8'hC0);
    rd_chk(8'h0C, 8'h00);
    check({rate, timer, sw_on, probe, alert}, 5'h0C);
    $display("test reset done");
  endtask

  task automatic test_fields();
    wr(8'h0A, 8'h80);
    check({rate, timer}, 2'h2);
    wr(8'h0A, 8'h4C);
    check({rate, timer}, 2'h1);
    rd_chk(8'h0A, 8'h4C);
    wr(8'h0B, 8'hFF);
    check(probe, 1'b1);
    rd_chk(8'h0B, 8'hE0);
    wr(8'h0B, 8'h1F);
    check(probe, 1'b0);
    rd_chk(8'h0B, 8'h00);
    $display("test fields done");
  endtask

  // a write while the enable is low must leave no trace
  task automatic test_freeze();
    @(negedge clock) clk_en = 1'b0;
    wr(8'h0A, 8'hCC);
    check(rate, 1'b0);
    @(negedge clock) clk_en = 1'b1;
    rd_chk(8'h0A, 8'h4C);
    wr(8'h0A, 8'hCC);
    check(rate, 1'b1);
    $display("test freeze done");
  endtask

  task automatic test_restore();
    wr(8'h0B, 8'h20);
    wr(8'h0A, 8'h20);
    check(sw_on, 1'b0);
    @(negedge clock) wdog = 1'b1;
    @(negedge clock) wdog = 1'b0;
    rd_chk(8'h0A, 8'h68);
    rd_chk(8'h0B, 8'hC0);
    @(negedge clock) reg_reset = 1'b1;
    @(negedge clock) reg_reset = 1'b0;
    rd_chk(8'h0A, 8'h78);
    check(sw_on, 1'b0);
    wr(8'h0A, 8'h00);
    check(sw_on, 1'b1);
    $display("test restore done");
  endtask

  task automatic test_alerts();
    logic [2:0] f;
    for (int m = 0; m < 4; m++) begin
      wr(8'h0B, {m[1:0], 6'h00});
      for (int k = 0; k < 3; k++) begin
        f = 3'h1 << k;
        faults = f;
        repeat (5) @(negedge clock);
        check(alert, (m[1] & (f[2] | f[1])) | (m[0] & f[0]));
        faults = 3'h0;
        repeat (5) @(negedge clock);
        check(alert, 1'b0);
      end
    end
    $display("test alerts done");
  endtask

  task automatic test_soft();
    wr(8'h0A, 8'h10);
    host_model_i.set_pin(1'b0);
    wait_switch(1'b0, 8000 * MSC + 20);
    band(8000 * MSC - 4, 8000 * MSC + 8);
    wait_switch(1'b1, 500 * MSC + 20);
    band(500 * MSC - 4, 500 * MSC + 8);
    repeat (100) @(negedge clock);
    check(sw_on, 1'b1);
    host_model_i.set_pin(1'b1);
    $display("test software restart done");
  endtask

  // 12 s hold and 2 s restart-off codes
  task automatic test_soft_slow();
    wr(8'h0A, 8'h16);
    host_model_i.set_pin(1'b0);
    wait_switch(1'b0, 12000 * MSC + 20);
    band(12000 * MSC - 4, 12000 * MSC + 8);
    wait_switch(1'b1, 2000 * MSC + 20);
    band(2000 * MSC - 4, 2000 * MSC + 8);
    host_model_i.set_pin(1'b1);
    $display("test slow software restart done");
  endtask

  task automatic test_hard();
    wr(8'h0A, 8'h09);
    host_model_i.set_pin(1'b0);
    wait_switch(1'b0, 10000 * MSC + 20);
    band(10000 * MSC - 4, 10000 * MSC + 8);
    host_model_i.set_pin(1'b1);
    repeat (100) @(negedge clock);
    check(sw_on, 1'b0);
    host_model_i.set_pin(1'b0);
    repeat (100 * MSC) @(negedge clock);
    host_model_i.set_pin(1'b1);
    repeat (20) @(negedge clock);
    check(sw_on, 1'b0);
    host_model_i.set_pin(1'b0);
    wait_switch(1'b1, 4000 * MSC + 20);
    band(4000 * MSC - 4, 4000 * MSC + 8);
    host_model_i.set_pin(1'b1);
    $display("test hardware restart done");
  endtask

  // -------------------------------------------------------------------
  // clock, reset and sequence
  // -------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial begin
    rst_n = 1'b0;
    reg_reset = 1'b0;
    wdog = 1'b0;
    clk_en = 1'b1;
    faults = 3'h0;
    error_cnt = 0;
    compares = 0;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    test_reset();
    test_fields();
    test_freeze();
    test_restore();
    test_alerts();
    test_soft();
    test_soft_slow();
    test_hard();
    print_verdict();
  end
endmodule

`default_nettype wire
